/* xor_chain_loader.sv */
/*
 * xor chain engine: fetches linked descriptors, loads the working registers,
 * then reads each enabled source byte, xors them and writes the destination.
 * assumes a memory controller that holds mem_ack high for one cycle with read
 * data, and an apb master on the register side.
 */
// The register addresses and the APB register port were chosen for this implementation.
// Overview of operation
// - read every enabled source, xor bytewise, write result to destination.
// - one descriptor per transfer; follow next links in order.
// - descriptor words are read from consecutive addresses; formats are decoded.
// - per-source enable mask lets only some sources take part.
// - with raid-6 mode on, plain layouts are refused.
// - in raid-6 mode multiplier bytes act as control values; this engine refuses every descriptor while raid-6 is on.
// - four-source descriptor is eight words on an eight-word boundary.
// - word one loads next pointer; zero ends the chain.
// - low five bits of the next pointer are ignored.
// - word two loads first source or the fill value.
// - words three to five load sources two to four.
// - word six loads the destination address.
// - word seven loads the byte count.
// - word eight loads the descriptor control register.
// - any byte alignment of source and destination is handled.
// - eight-source descriptor is twelve words on a sixteen-word boundary.
// - words nine to twelve load sources five to eight.
// - raid-6 mode is one enable bit in the engine control register.
module xor_chain_loader
	import xor_chain_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic mem_req,
	output mem_cmd_t mem_cmd,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata
);
	// ==========================================================
	// working registers
	eng_state_t state_reg;
	logic [31:0] engine_control_reg;
	logic [2:0] engine_status_reg;
	logic [31:0] current_desc_addr_reg;
	logic [31:0] next_desc_addr_reg;
	logic [31:0] src_reg [NUM_SRC];
	logic [31:0] dest_addr_reg;
	logic [31:0] byte_count_reg;
	logic [31:0] desc_control_reg;
	logic [3:0] word_idx_reg;
	logic [2:0] src_idx_reg;
	logic [31:0] pos_reg;
	logic [7:0] acc_reg;
	logic [31:0] prdata_next;
	logic unmapped;
	logic apb_wr;
	logic apb_setup;
	logic [1:0] fmt;
	logic fmt_bad;
	logic [3:0] last_src;
	logic [2:0] first_src;
	logic [2:0] next_src;
	logic next_src_ok;
	logic [31:0] rd_addr;
	logic [31:0] wr_addr;
	logic [7:0] rd_byte;

	assign apb_setup = psel && !penable && !pready;
	assign apb_wr = psel && penable && pready && pwrite;
	assign fmt = mem_rdata[DC_FMT_LSB +: 2];
	// plain layouts refused when raid-6 is on; wide formats unsupported
	assign fmt_bad = engine_control_reg[CTL_PQ_BIT] || (fmt != FMT_FOUR && fmt != FMT_EIGHT);
	// eight-source format widens the source set to eight
	assign last_src = (desc_control_reg[DC_FMT_LSB +: 2] == FMT_EIGHT) ? 4'd8 : 4'd4;
	// byte addresses carry any alignment, word lane picked below
	assign rd_addr = src_reg[src_idx_reg] + pos_reg;
	assign wr_addr = dest_addr_reg + pos_reg;
	assign rd_byte = mem_rdata[{rd_addr[1:0], 3'b000} +: 8];

	// ==========================================================
	// source selection: first and following enabled source
	// only sources whose mask bit is set take part, or source one when no bit is set
	always_comb begin
		first_src = 3'd0;
		next_src = 3'd0;
		next_src_ok = 1'b0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (i < int'(last_src) && desc_control_reg[i]) begin
				first_src = 3'(i);
				if (i > int'(src_idx_reg)) begin
					next_src = 3'(i);
					next_src_ok = 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// apb read mux and address decode
	always_comb begin
		prdata_next = RESET_WORD;
		unmapped = 1'b0;
		if (paddr == OFS_CONTROL) begin
			prdata_next = engine_control_reg;
		end else if (paddr == OFS_STATUS) begin
			prdata_next = {29'h0, engine_status_reg};
		end else if (paddr == OFS_CUR_DESC) begin
			prdata_next = current_desc_addr_reg;
		end else if (paddr == OFS_NEXT_DESC) begin
			prdata_next = next_desc_addr_reg;
		end else if (paddr >= OFS_SRC_BASE && paddr < OFS_DEST && paddr[1:0] == 2'h0) begin
			prdata_next = src_reg[3'(paddr[7:2] - OFS_SRC_BASE[7:2])];
		end else if (paddr == OFS_DEST) begin
			prdata_next = dest_addr_reg;
		end else if (paddr == OFS_BCOUNT) begin
			prdata_next = byte_count_reg;
		end else if (paddr == OFS_DCTRL) begin
			prdata_next = desc_control_reg;
		end else begin
			unmapped = 1'b1;
		end
	end

	// apb handshake: no wait state, answer registered
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pready <= 1'b0;
			prdata <= RESET_WORD;
			pslverr <= 1'b0;
		end else begin
			pready <= apb_setup;
			pslverr <= apb_setup && unmapped;
			if (apb_setup) begin
				prdata <= pwrite ? RESET_WORD : prdata_next;
			end
		end
	end

	// ==========================================================
	// control register; start bit drops when the chain ends
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			engine_control_reg <= RESET_WORD;
		end else if (apb_wr && paddr == OFS_CONTROL) begin
			// raid-6 enable sits at its own bit
			engine_control_reg <= pwdata;
		end else if (state_reg == ST_NEXT && next_desc_addr_reg == RESET_WORD) begin
			engine_control_reg[CTL_START_BIT] <= 1'b0;
		end else if (state_reg == ST_FETCH && mem_ack && word_idx_reg == 4'd7 && fmt_bad) begin
			engine_control_reg[CTL_START_BIT] <= 1'b0;
		end
	end

	// status: done and error are sticky, write one to clear; a set wins
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			engine_status_reg <= 3'h0;
		end else begin
			engine_status_reg[STS_ACTIVE_BIT] <= (state_reg != ST_IDLE);
			if (state_reg == ST_NEXT && next_desc_addr_reg == RESET_WORD) begin
				engine_status_reg[STS_DONE_BIT] <= 1'b1;
			end else if (apb_wr && paddr == OFS_STATUS && pwdata[STS_DONE_BIT]) begin
				engine_status_reg[STS_DONE_BIT] <= 1'b0;
			end
			// multiplier controls are not carried, so raid-6 work is an error
			if (state_reg == ST_FETCH && mem_ack && word_idx_reg == 4'd7 && fmt_bad) begin
				engine_status_reg[STS_ERR_BIT] <= 1'b1;
			end else if (apb_wr && paddr == OFS_STATUS && pwdata[STS_ERR_BIT]) begin
				engine_status_reg[STS_ERR_BIT] <= 1'b0;
			end
		end
	end

	// ==========================================================
	// descriptor pointer; software sets the chain head while idle
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			current_desc_addr_reg <= RESET_WORD;
		end else if (apb_wr && paddr == OFS_CUR_DESC && state_reg == ST_IDLE) begin
			// heads are on eight-word boundaries at least
			current_desc_addr_reg <= {pwdata[31:DESC_ALIGN_BITS], 5'h00};
		end else if (state_reg == ST_NEXT && next_desc_addr_reg != RESET_WORD) begin
			current_desc_addr_reg <= next_desc_addr_reg;
		end
	end

	// descriptor word loading, one word per memory answer
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			next_desc_addr_reg <= RESET_WORD;
			dest_addr_reg <= RESET_WORD;
			byte_count_reg <= RESET_WORD;
			desc_control_reg <= RESET_WORD;
			for (int i = 0; i < NUM_SRC; i++) begin
				src_reg[i] <= RESET_WORD;
			end
		end else if (state_reg == ST_FETCH && mem_ack) begin
			case (word_idx_reg)
				// next pointer; low five bits dropped
				4'd0: next_desc_addr_reg <= {mem_rdata[31:DESC_ALIGN_BITS], 5'h00};
				4'd1: src_reg[0] <= mem_rdata;
				4'd2, 4'd3, 4'd4: src_reg[3'(word_idx_reg - 4'd1)] <= mem_rdata;
				4'd5: dest_addr_reg <= mem_rdata;
				4'd6: byte_count_reg <= mem_rdata;
				4'd7: desc_control_reg <= mem_rdata;
				default: src_reg[3'(word_idx_reg - 4'd4)] <= mem_rdata;
			endcase
		end
	end

	// ==========================================================
	// sequencer: fetch, read sources, write result, next link
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= ST_IDLE;
			word_idx_reg <= 4'd0;
			src_idx_reg <= 3'd0;
			pos_reg <= RESET_WORD;
			acc_reg <= 8'h00;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					word_idx_reg <= 4'd0;
					// software has placed the chain before this write
					if (apb_wr && paddr == OFS_CONTROL && pwdata[CTL_START_BIT]) begin
						state_reg <= ST_FETCH;
					end
				end
				ST_FETCH: begin
					if (mem_ack) begin
						word_idx_reg <= word_idx_reg + 4'd1;
						// sources are read only after the last word
						if (word_idx_reg == 4'd7 && fmt_bad) begin
							state_reg <= ST_IDLE;
						end else if ((word_idx_reg == 4'd7 && fmt == FMT_FOUR)
							|| word_idx_reg == 4'(WORDS_EIGHT - 1)) begin
							// twelve words for the eight-source form
							pos_reg <= RESET_WORD;
							acc_reg <= 8'h00;
							src_idx_reg <= 3'd0;
							state_reg <= ST_READ;
						end
					end
				end
				ST_READ: begin
					if (byte_count_reg == pos_reg) begin
						state_reg <= ST_NEXT;
					end else if (desc_control_reg[DC_FILL_BIT]) begin
						// fill takes its byte from the first data word
						acc_reg <= src_reg[0][{pos_reg[1:0], 3'b000} +: 8];
						state_reg <= ST_WRITE;
					end else if (src_idx_reg < first_src) begin
						src_idx_reg <= first_src;
					end else if (mem_ack) begin
						acc_reg <= acc_reg ^ rd_byte;
						if (next_src_ok) begin
							src_idx_reg <= next_src;
						end else begin
							state_reg <= ST_WRITE;
						end
					end
				end
				ST_WRITE: begin
					if (mem_ack) begin
						pos_reg <= pos_reg + 32'd1;
						acc_reg <= 8'h00;
						src_idx_reg <= 3'd0;
						state_reg <= ST_READ;
					end
				end
				ST_NEXT: begin
					word_idx_reg <= 4'd0;
					state_reg <= (next_desc_addr_reg == RESET_WORD) ? ST_IDLE : ST_FETCH;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// memory master: request held until ack, then one idle cycle
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			mem_req <= 1'b0;
			mem_cmd <= '0;
		end else if (mem_req) begin
			if (mem_ack) begin
				mem_req <= 1'b0;
			end
		end else if (state_reg == ST_FETCH) begin
			mem_req <= 1'b1;
			mem_cmd <= '{1'b0, current_desc_addr_reg + {26'h0, word_idx_reg, 2'b00}, RESET_WORD, 4'hF};
		end else if (state_reg == ST_READ && byte_count_reg != pos_reg
			&& !desc_control_reg[DC_FILL_BIT] && src_idx_reg >= first_src) begin
			mem_req <= 1'b1;
			mem_cmd <= '{1'b0, {rd_addr[31:2], 2'b00}, RESET_WORD, 4'hF};
		end else if (state_reg == ST_WRITE) begin
			// single-byte lane write suits any destination alignment
			mem_req <= 1'b1;
			mem_cmd <= '{1'b1, {wr_addr[31:2], 2'b00}, {4{acc_reg}}, 4'(4'h1 << wr_addr[1:0])};
		end
	end
endmodule

/* xor_chain_pkg.sv */
/*
 * shared constants and carriers of the descriptor-driven xor engine.
 * assumes a 32-bit byte-addressed local memory bus and an apb register bus.
 */
package xor_chain_pkg;
	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_CUR_DESC = 8'h08;
	localparam logic [7:0] OFS_NEXT_DESC = 8'h0C;
	localparam logic [7:0] OFS_SRC_BASE = 8'h10; // sources one to eight, 0x10..0x2C
	localparam logic [7:0] OFS_DEST = 8'h30;
	localparam logic [7:0] OFS_BCOUNT = 8'h34;
	localparam logic [7:0] OFS_DCTRL = 8'h38;
	// ==========================================================
	// field positions
	localparam int CTL_START_BIT = 0;
	localparam int CTL_PQ_BIT = 3;
	localparam int STS_ACTIVE_BIT = 0;
	localparam int STS_DONE_BIT = 1;
	localparam int STS_ERR_BIT = 2;
	localparam int DC_FILL_BIT = 8;
	localparam int DC_FMT_LSB = 9;   // two bits: 0 four, 1 eight, 2 sixteen, 3 thirty-two
	localparam logic [1:0] FMT_FOUR = 2'h0;
	localparam logic [1:0] FMT_EIGHT = 2'h1;
	// ==========================================================
	// descriptor layout
	localparam int WORDS_FOUR = 8;
	localparam int WORDS_EIGHT = 12;
	localparam int NUM_SRC = 8;
	localparam int DESC_ALIGN_BITS = 5;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	// ==========================================================
	// carriers
	typedef struct packed {
		logic we;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0] be;
	} mem_cmd_t;
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_FETCH = 5'b00010,
		ST_READ = 5'b00100,
		ST_WRITE = 5'b01000,
		ST_NEXT = 5'b10000
	} eng_state_t;
endpackage

/* xor_chain_loader_assertions.sv */
/* port-level checker of the xor chain engine: apb answer and memory request rules.
 * assumes it is bound to xor_chain_loader and sees only its ports. */
module xor_chain_loader_assertions
	import xor_chain_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic mem_req,
	input wire mem_cmd_t mem_cmd,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	logic armed_reg;
	// ==========================================================
	// start write arms a watch on the first request after it
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			armed_reg <= 1'b0;
		else if (mem_req)
			armed_reg <= 1'b0;
		else if (psel && penable && pready && pwrite && paddr == OFS_CONTROL && pwdata[0])
			armed_reg <= 1'b1;
	end
	// ==========================================================
	// properties
	property p_req_hold;
		mem_req && !mem_ack |=> mem_req && $stable(mem_cmd);
	endproperty
	property p_req_gap;
		mem_req && mem_ack |=> !mem_req;
	endproperty
	property p_setup_answer;
		psel && !penable |=> pready;
	endproperty
	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	property p_unmapped;
		psel && penable && pready && paddr >= 8'h3C |-> pslverr && prdata == 32'h0;
	endproperty
	property p_mapped;
		psel && penable && pready && paddr < 8'h3C && paddr[1:0] == 2'h0 |-> !pslverr;
	endproperty
	property p_wr_lane;
		mem_req && mem_cmd.we |-> $onehot(mem_cmd.be) && mem_cmd.addr[1:0] == 2'h0;
	endproperty
	property p_wr_repl;
		mem_req && mem_cmd.we |-> mem_cmd.wdata == {4{mem_cmd.wdata[7:0]}};
	endproperty
	property p_rd_word;
		mem_req && !mem_cmd.we |-> mem_cmd.addr[1:0] == 2'h0;
	endproperty
	property p_start_fetch;
		$rose(armed_reg) |-> ##[0:8] mem_req;
	endproperty
	property p_first_desc;
		armed_reg && mem_req |-> !mem_cmd.we && mem_cmd.addr[4:0] == 5'h0;
	endproperty
	a_req_hold: assert property (p_req_hold)
		else $error("memory request changed before ack");
	a_req_gap: assert property (p_req_gap)
		else $error("memory request not dropped after ack");
	a_setup_answer: assert property (p_setup_answer)
		else $error("no pready after setup");
	a_ready_pulse: assert property (p_ready_pulse)
		else $error("pready longer than one cycle");
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped access not refused");
	a_mapped: assert property (p_mapped)
		else $error("mapped access refused");
	a_wr_lane: assert property (p_wr_lane)
		else $error("write lane enable wrong");
	a_wr_repl: assert property (p_wr_repl)
		else $error("write byte not replicated");
	a_rd_word: assert property (p_rd_word)
		else $error("read not word aligned");
	a_start_fetch: assert property (p_start_fetch)
		else $error("no fetch after start");
	a_first_desc: assert property (p_first_desc)
		else $error("first request not an aligned descriptor read");
	c_write: cover property (mem_req && mem_cmd.we && mem_ack);
	c_refuse: cover property (pslverr);
	c_slow: cover property (mem_req && !mem_ack [*3]);
endmodule

bind xor_chain_loader xor_chain_loader_assertions xor_chain_loader_assertions_inst (
	.core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.mem_req(mem_req), .mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

/* xor_chain_mem_model.sv */
/* memory controller model: 4 kbyte word array, acks each request after 0..3 cycles.
 * assumes the engine holds mem_req and mem_cmd until ack. */
module xor_chain_mem_model
	import xor_chain_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic mem_req,
	input wire mem_cmd_t mem_cmd,
	output logic mem_ack,
	output logic [31:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [1024];
	logic [1:0] wait_cnt;
	logic [7:0] lfsr;
	// main memory only
	// one request at a time; idle data bus toggles so stale data never looks valid
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			mem_ack <= 1'b0;
			mem_rdata <= 32'h0;
			wait_cnt <= 2'h0;
			lfsr <= 8'h5A;
		end else begin
			lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (mem_req && !mem_ack && wait_cnt != 2'h0)
				wait_cnt <= wait_cnt - 2'h1;
			else if (mem_req && !mem_ack) begin
				mem_ack <= 1'b1;
				wait_cnt <= lfsr[1:0];
				if (!mem_cmd.we)
					mem_rdata <= mem[mem_cmd.addr[11:2]];
				for (int b = 0; b < 4; b++)
					if (mem_cmd.we && mem_cmd.be[b])
						mem[mem_cmd.addr[11:2]][8 * b +: 8] <= mem_cmd.wdata[8 * b +: 8];
			end
		end
	end
endmodule

/* xor_chain_loader_tb_top.sv */
/* bench for the xor chain engine: apb driver, linked descriptors, result compare.
 * assumes the memory model array can be preloaded and read by hierarchy. */
module xor_chain_loader_tb_top
	import xor_chain_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic mem_req, mem_ack, pready, pslverr;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata, mem_rdata, seed = 32'h63, bca, bcb, src [8];
	logic [7:0] expq [$];
	mem_cmd_t mem_cmd;
	int num_errors = 0, num_checks = 0;
	// 200 MHz
	always #2.5 core_clk = ~core_clk;
	xor_chain_loader xor_chain_loader_inst (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_cmd(mem_cmd),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata));
	xor_chain_mem_model mem_model_inst (.core_clk(core_clk), .arst_n(arst_n),
		.mem_req(mem_req), .mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
	// ==========================================================
	// helpers
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [31:0] mbyte(input logic [31:0] a);
		return {24'h0, mem_model_inst.mem[a[11:2]][8 * a[1:0] +: 8]};
	endfunction
	task automatic complete_run();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// apb transfer; one idle edge after so strobes never change twice in a step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		for (int n = 0; n < 16; n++) begin
			@(posedge core_clk);
			if (pready === 1'b1)
				break;
		end
		r = prdata;
		e = pslverr;
		if (pready !== 1'b1) begin
			num_errors++;
			complete_run();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, x);
		chk({31'h0, e}, {31'h0, xe});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	// lay a descriptor into memory and queue the bytes it must produce
	task automatic put(input logic [31:0] base, nxt, dst, bc, ctl, input int nw);
		logic [31:0] w [12];
		logic [7:0] acc;
		for (int i = 0; i < 8; i++)
			src[i] = 32'h400 + 32'h40 * i + (rnd() & 32'h1F);
		if (ctl[8])
			src[0] = 32'h0101_0101 * (rnd() & 32'hFF);
		w = '{nxt, src[0], src[1], src[2], src[3], dst, bc, ctl, src[4], src[5], src[6], src[7]};
		for (int i = 0; i < nw; i++)
			mem_model_inst.mem[base[11:2] + i] = w[i];
		for (int p = 0; p < bc; p++) begin
			acc = ctl[8] ? src[0][7:0] : 8'h0;
			for (int i = 0; i < 8; i++)
				if (!ctl[8] && ctl[i])
					acc ^= mbyte(src[i] + p);
			expq.push_back(acc);
		end
	endtask
	// start at head, poll until done or error, then clear both flags
	task automatic run(input logic [31:0] head, cv, es);
		logic [31:0] r;
		logic e;
		int n;
		r = 32'h0;
		wr(OFS_CUR_DESC, head);
		wr(OFS_CONTROL, cv);
		for (n = 0; n < 3000 && r[2:1] == 2'h0; n++)
			apb(1'b0, OFS_STATUS, 32'h0, r, e);
		if (n == 3000) begin
			num_errors++;
			complete_run();
		end
		chk(r & 32'h6, es);
		wr(OFS_STATUS, 32'h6);
		rd(OFS_STATUS, 32'h0, 1'b0);
	endtask
	task automatic verify(input logic [31:0] dst, bc);
		for (int p = 0; p < bc; p++)
			chk(mbyte(dst + p), {24'h0, expq.pop_front()});
		chk(mbyte(dst + bc), 32'h0);
	endtask
	// ==========================================================
	// main sequence
	initial begin
		for (int i = 0; i < 1024; i++)
			mem_model_inst.mem[i] = i < 512 ? rnd() : 32'h0;
		repeat (4) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		// reset values; last offset is unmapped; read-only write ignored
		for (int a = 0; a < 16; a++)
			rd(8'(4 * a), 32'h0, a == 15);
		wr(OFS_NEXT_DESC, 32'hFFFF_FFFF);
		rd(OFS_NEXT_DESC, 32'h0, 1'b0);
		bca = (rnd() & 32'hF) + 1;
		bcb = (rnd() & 32'hF) + 1;
		put(32'h100, 32'h213, 32'h803, bca, 32'h5, 8);
		put(32'h200, 32'h0, 32'h861, bcb, 32'h2FF, 12);
		run(32'h100, 32'h1, 32'h2);
		verify(32'h803, bca);
		verify(32'h861, bcb);
		for (int i = 0; i < 8; i++)
			rd(8'(OFS_SRC_BASE + 4 * i), src[i], 1'b0);
		rd(OFS_DEST, 32'h861, 1'b0);
		rd(OFS_BCOUNT, bcb, 1'b0);
		rd(OFS_DCTRL, 32'h2FF, 1'b0);
		rd(OFS_NEXT_DESC, 32'h0, 1'b0);
		rd(OFS_CUR_DESC, 32'h200, 1'b0);
		// block fill, no source reads
		put(32'h300, 32'h0, 32'h8C2, 32'h7, 32'h101, 8);
		run(32'h300, 32'h1, 32'h2);
		verify(32'h8C2, 32'h7);
		// random eight-source descriptors, first one with zero count
		for (int k = 0; k < 3; k++) begin
			bca = k == 0 ? 32'h0 : (rnd() & 32'h7) + 1;
			put(32'h200, 32'h0, 32'h900 + 32'h21 * k, bca, (rnd() & 32'hFF) | 32'h201, 12);
			run(32'h200, 32'h1, 32'h2);
			verify(32'h900 + 32'h21 * k, bca);
		end
		// raid-6 mode refuses the plain layout and writes nothing
		put(32'h100, 32'h0, 32'h8E0, 32'h4, 32'h5, 8);
		expq.delete();
		run(32'h100, 32'h9, 32'h4);
		rd(OFS_CONTROL, 32'h8, 1'b0);
		chk(mbyte(32'h8E0), 32'h0);
		wr(OFS_CONTROL, 32'h0);
		// unsupported wide format is refused the same way
		put(32'h100, 32'h0, 32'h8E0, 32'h4, 32'h405, 8);
		expq.delete();
		run(32'h100, 32'h1, 32'h4);
		rd(OFS_CONTROL, 32'h0, 1'b0);
		chk(mbyte(32'h8E0), 32'h0);
		complete_run();
	end
endmodule
